// File: design/ocf_pkg.sv
// Package for the over-current fault response block: command codes,
// field positions, reset values, response codes and timing constants.
// Assumes one 20 MHz clock shared by every user of this package.
package ocf_pkg;

  // Command codes of the three registers
  localparam logic [7:0] CMD_THRESHOLD = 8'h46;
  localparam logic [7:0] CMD_REACTION = 8'h47;
  localparam logic [7:0] CMD_TIME_UNIT = 8'hD2;

  // Reaction config field positions
  localparam int RESP_MSB = 7;
  localparam int RESP_LSB = 6;
  localparam int RETRY_MSB = 5;
  localparam int RETRY_LSB = 3;
  localparam int RTIME_MSB = 2;
  localparam int RTIME_LSB = 0;

  // Reset values
  localparam logic [15:0] THRESHOLD_RST = 16'hFFFF;
  localparam logic [7:0] REACTION_RST = 8'h00;
  localparam logic [7:0] TIME_UNIT_RST = 8'h00;

  // Response codes
  localparam logic [1:0] RESP_CC = 2'h0;
  localparam logic [1:0] RESP_CC_LV = 2'h1;
  localparam logic [1:0] RESP_DELAY = 2'h2;
  localparam logic [1:0] RESP_SHUTDOWN = 2'h3;

  // Retry codes
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;

  // Time base: one tick is 1 us, a time unit is (time unit register + 1) ticks
  localparam int CLK_NS = 50;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;

  typedef enum logic [2:0] {
    ST_OFF = 3'h0,
    ST_RUN = 3'h1,
    ST_LIMIT = 3'h2,
    ST_WAIT = 3'h3,
    ST_LATCH = 3'h4
  } ocf_state_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] code;
    logic [15:0] data;
  } ocf_req_s;

  typedef struct packed {
    logic [1:0] resp;
    logic [2:0] retry;
    logic [2:0] rtime;
  } ocf_cfg_s;

endpackage

// File: design/ocf_fault_ctrl.sv
// Over-current fault response controller with its three registers.
// Assumes all inputs synchronous to clock; the current measurement uses the
// same linear encoding as the threshold register, so a plain compare works.
//
// Overview of operation
// - Code 110: six restarts, then latch off
// - Code 111: retry until off, bias loss, fault
// - Restart spacing is count times delay unit
// - Delay count is two to field value
// - Same count times limiting or retry spacing
// - Unit length comes from time-unit register
// - 16-bit threshold is the current limit
// - Every response sets status and notifies host
// - Code 00: clamp current forever, never shut
// - Code 01: clamp, shut down on low voltage
// - Code 10: clamp for delay, then retry
// - Code 11: shut down at once, then retry
// - Code 000: no restarts, latch off
// - Codes 001-101: that many restarts, then latch
`timescale 1ns/1ps
`default_nettype none

module ocf_fault_ctrl #(
  parameter int TICK_CYCLES = ocf_pkg::TICK_CYC
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire ocf_pkg::ocf_req_s reg_req,
  input wire logic [15:0] iout_meas,
  input wire logic vout_low,
  input wire logic output_on_cmd,
  input wire logic bias_ok,
  input wire logic other_fault,
  input wire logic fault_clear,
  output logic [15:0] rd_data_r,
  output logic rd_valid_r,
  output logic out_enable_r,
  output logic clamp_active_r,
  output logic [15:0] current_limit_r,
  output logic oc_status_r,
  output logic host_notify_r,
  output logic [2:0] attempts_r
);

  // Tick counter is 16 bits wide
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535) begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  ocf_pkg::ocf_state_e state_r, state_nxt;
  logic [15:0] thr_nxt;
  logic [7:0] cfg_r, cfg_nxt;
  logic [7:0] tu_r, tu_nxt;
  logic [15:0] rd_data_nxt;
  logic rd_valid_nxt;
  logic out_enable_nxt, clamp_active_nxt, oc_status_nxt, host_notify_nxt;
  logic [2:0] attempts_nxt;
  logic [15:0] tick_cnt_r, tick_cnt_nxt;
  logic [7:0] unit_cnt_r, unit_cnt_nxt;
  logic [7:0] dly_cnt_r, dly_cnt_nxt;
  logic tmr_done_r, tmr_done_nxt;
  logic tmr_start;
  logic tmr_expire;
  logic restarted_r, restarted_nxt;
  logic oc;
  logic tick, unit;
  logic enabled;
  ocf_pkg::ocf_cfg_s cfg;

  // Two raised to the retry time field
  function automatic logic [7:0] delay_units(input logic [2:0] code);
    delay_units = 8'h01 << code;
  endfunction

  // Next state after the output is shut down by the fault
  function automatic ocf_pkg::ocf_state_e after_shutdown(input logic [2:0] retry,
                                                         input logic [2:0] used);
    if (retry == ocf_pkg::RETRY_NONE) begin
      after_shutdown = ocf_pkg::ST_LATCH;
    end else if (retry == ocf_pkg::RETRY_FOREVER) begin
      after_shutdown = ocf_pkg::ST_WAIT;
    end else if (used >= retry) begin
      after_shutdown = ocf_pkg::ST_LATCH;
    end else begin
      after_shutdown = ocf_pkg::ST_WAIT;
    end
  endfunction

  assign cfg = ocf_pkg::ocf_cfg_s'(cfg_r);
  assign oc = iout_meas > current_limit_r;
  assign enabled = output_on_cmd && bias_ok && !other_fault;

  // Delay timer: ticks of 1 us, units of (tu + 1) ticks, count of 2^n units
  assign tick = (tick_cnt_r == 16'(TICK_CYCLES - 1));
  assign unit = tick && (unit_cnt_r == tu_r);
  // Seen by the sequencer at the same edge, so the delay gains no extra cycle
  assign tmr_expire = unit && !tmr_done_r && (dly_cnt_r == delay_units(cfg.rtime) - 8'h01);

  always_comb begin
    tick_cnt_nxt = tick ? 16'h0000 : tick_cnt_r + 16'h0001;
    unit_cnt_nxt = !tick ? unit_cnt_r : (unit ? 8'h00 : unit_cnt_r + 8'h01);
    dly_cnt_nxt = dly_cnt_r;
    tmr_done_nxt = tmr_done_r;
    if (tmr_expire) begin
      tmr_done_nxt = 1'b1;
    end else if (unit && !tmr_done_r) begin
      dly_cnt_nxt = dly_cnt_r + 8'h01;
    end
    if (tmr_start) begin
      tick_cnt_nxt = 16'h0000;
      unit_cnt_nxt = 8'h00;
      dly_cnt_nxt = 8'h00;
      tmr_done_nxt = 1'b0;
    end
  end

  // Register access by command code
  always_comb begin
    thr_nxt = current_limit_r;
    cfg_nxt = cfg_r;
    tu_nxt = tu_r;
    rd_data_nxt = rd_data_r;
    rd_valid_nxt = reg_req.rd;
    if (reg_req.wr) begin
      unique case (reg_req.code)
        ocf_pkg::CMD_THRESHOLD: thr_nxt = reg_req.data;
        ocf_pkg::CMD_REACTION: cfg_nxt = reg_req.data[7:0];
        ocf_pkg::CMD_TIME_UNIT: tu_nxt = reg_req.data[7:0];
        default: thr_nxt = current_limit_r;
      endcase
    end
    if (reg_req.rd) begin
      unique case (reg_req.code)
        ocf_pkg::CMD_THRESHOLD: rd_data_nxt = current_limit_r;
        ocf_pkg::CMD_REACTION: rd_data_nxt = {8'h00, cfg_r};
        ocf_pkg::CMD_TIME_UNIT: rd_data_nxt = {8'h00, tu_r};
        default: rd_data_nxt = 16'h0000;
      endcase
    end
  end

  // Fault response sequencer
  always_comb begin
    state_nxt = state_r;
    out_enable_nxt = 1'b0;
    clamp_active_nxt = 1'b0;
    host_notify_nxt = 1'b0;
    oc_status_nxt = oc_status_r && !fault_clear;
    attempts_nxt = attempts_r;
    tmr_start = 1'b0;
    restarted_nxt = restarted_r;
    unique case (state_r)
      ocf_pkg::ST_OFF: begin
        attempts_nxt = 3'h0;
        restarted_nxt = 1'b0;
        if (enabled) begin
          state_nxt = ocf_pkg::ST_RUN;
          out_enable_nxt = 1'b1;
        end
      end
      ocf_pkg::ST_RUN: begin
        out_enable_nxt = 1'b1;
        if (oc) begin
          oc_status_nxt = 1'b1;
          host_notify_nxt = 1'b1;
          unique case (cfg.resp)
            ocf_pkg::RESP_CC, ocf_pkg::RESP_CC_LV, ocf_pkg::RESP_DELAY: begin
              state_nxt = ocf_pkg::ST_LIMIT;
              clamp_active_nxt = 1'b1;
              tmr_start = 1'b1;
            end
            ocf_pkg::RESP_SHUTDOWN: begin
              state_nxt = after_shutdown(cfg.retry, attempts_r);
              out_enable_nxt = 1'b0;
              // Only the first shutdown starts the spacing; later ones run from the restart
              if (!restarted_r) begin
                tmr_start = 1'b1;
              end
            end
          endcase
        end
      end
      ocf_pkg::ST_LIMIT: begin
        out_enable_nxt = 1'b1;
        clamp_active_nxt = 1'b1;
        if ((cfg.resp == ocf_pkg::RESP_CC_LV && vout_low) ||
            (cfg.resp == ocf_pkg::RESP_DELAY && (tmr_done_r || tmr_expire) && oc) ||
            cfg.resp == ocf_pkg::RESP_SHUTDOWN) begin
          state_nxt = after_shutdown(cfg.retry, attempts_r);
          out_enable_nxt = 1'b0;
          clamp_active_nxt = 1'b0;
          tmr_start = 1'b1;
        end else if (!oc) begin
          state_nxt = ocf_pkg::ST_RUN;
          clamp_active_nxt = 1'b0;
        end
      end
      ocf_pkg::ST_WAIT: begin
        if (tmr_done_r || tmr_expire) begin
          state_nxt = ocf_pkg::ST_RUN;
          out_enable_nxt = 1'b1;
          tmr_start = 1'b1;
          restarted_nxt = 1'b1;
          if (cfg.retry != ocf_pkg::RETRY_FOREVER) begin
            attempts_nxt = attempts_r + 3'h1;
          end
        end
      end
      ocf_pkg::ST_LATCH: begin
        if (fault_clear) begin
          state_nxt = ocf_pkg::ST_OFF;
          attempts_nxt = 3'h0;
        end
      end
      default: state_nxt = ocf_pkg::ST_OFF;
    endcase
    // Off command, bias loss or another fault ends any sequence except a latch-off, which holds until cleared
    if (!enabled) begin
      state_nxt = (state_r == ocf_pkg::ST_LATCH && !fault_clear) ? ocf_pkg::ST_LATCH
                                                                 : ocf_pkg::ST_OFF;
      out_enable_nxt = 1'b0;
      clamp_active_nxt = 1'b0;
    end
    // A new event wins over a clear in the same cycle
    if (host_notify_nxt) begin
      oc_status_nxt = 1'b1;
    end
  end

  // Delay timer registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      tick_cnt_r <= 16'h0000;
      unit_cnt_r <= 8'h00;
      dly_cnt_r <= 8'h00;
      tmr_done_r <= 1'b0;
    end else begin
      tick_cnt_r <= tick_cnt_nxt;
      unit_cnt_r <= unit_cnt_nxt;
      dly_cnt_r <= dly_cnt_nxt;
      tmr_done_r <= tmr_done_nxt;
    end
  end

  // Configuration registers and read port
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      current_limit_r <= ocf_pkg::THRESHOLD_RST;
      cfg_r <= ocf_pkg::REACTION_RST;
      tu_r <= ocf_pkg::TIME_UNIT_RST;
      rd_data_r <= 16'h0000;
      rd_valid_r <= 1'b0;
    end else begin
      current_limit_r <= thr_nxt;
      cfg_r <= cfg_nxt;
      tu_r <= tu_nxt;
      rd_data_r <= rd_data_nxt;
      rd_valid_r <= rd_valid_nxt;
    end
  end

  // Sequencer registers
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= ocf_pkg::ST_OFF;
      out_enable_r <= 1'b0;
      clamp_active_r <= 1'b0;
      oc_status_r <= 1'b0;
      host_notify_r <= 1'b0;
      attempts_r <= 3'h0;
      restarted_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      out_enable_r <= out_enable_nxt;
      clamp_active_r <= clamp_active_nxt;
      oc_status_r <= oc_status_nxt;
      host_notify_r <= host_notify_nxt;
      attempts_r <= attempts_nxt;
      restarted_r <= restarted_nxt;
    end
  end

endmodule // ocf_fault_ctrl

`default_nettype wire

// File: verification/ocf_monitor.sv
// Port checker for the over-current fault controller.
// Assumes it is bound to ocf_fault_ctrl and sees the same port names.
`timescale 1ns/1ps
`default_nettype none
module ocf_monitor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire ocf_pkg::ocf_req_s reg_req,
  input wire logic [15:0] iout_meas,
  input wire logic vout_low,
  input wire logic output_on_cmd,
  input wire logic bias_ok,
  input wire logic other_fault,
  input wire logic fault_clear,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r,
  input wire logic out_enable_r,
  input wire logic clamp_active_r,
  input wire logic [15:0] current_limit_r,
  input wire logic oc_status_r,
  input wire logic host_notify_r,
  input wire logic [2:0] attempts_r
);
  logic [7:0] cfg_r, cfg_nxt;
  logic oc, en, run;
  assign oc = iout_meas > current_limit_r;
  assign en = output_on_cmd & bias_ok & !other_fault;
  assign run = out_enable_r & !clamp_active_r;
  // Shadow of the reaction config, same timing as the block's own copy
  always_comb begin
    cfg_nxt = cfg_r;
    if (reg_req.wr && reg_req.code == ocf_pkg::CMD_REACTION)
      cfg_nxt = reg_req.data[7:0];
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst)
      cfg_r <= ocf_pkg::REACTION_RST;
    else
      cfg_r <= cfg_nxt;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  rd_ans_a: assert property (rd_valid_r == $past(reg_req.rd)) else $error("read answer");
  lim_wr_a:
    assert property (reg_req.wr && reg_req.code == ocf_pkg::CMD_THRESHOLD |=> current_limit_r == $past(reg_req.data))
      else $error("limit write");
  notify_pulse_a: assert property (host_notify_r |-> oc_status_r ##1 !host_notify_r) else $error("notify");
  oc_notify_a: assert property (run && oc && en |=> host_notify_r && oc_status_r) else $error("no notify");
  off_force_a: assert property (!en |=> !out_enable_r) else $error("not off");
  cc_hold_a:
    assert property (cfg_r[7:6] == ocf_pkg::RESP_CC && out_enable_r && en |=> out_enable_r) else $error("cc shut");
  lv_shut_a:
    assert property (cfg_r[7:6] == ocf_pkg::RESP_CC_LV && clamp_active_r && vout_low |=> !out_enable_r)
      else $error("lv shut");
  fast_shut_a:
    assert property (cfg_r[7:6] == ocf_pkg::RESP_SHUTDOWN && run && oc |=> !out_enable_r) else $error("slow shut");
  cover property (host_notify_r && cfg_r[7:6] == ocf_pkg::RESP_SHUTDOWN);
  cover property (clamp_active_r && cfg_r[7:6] == ocf_pkg::RESP_DELAY);
  cover property ($rose(out_enable_r) && cfg_r[5:3] == ocf_pkg::RETRY_FOREVER);
endmodule // ocf_monitor
`default_nettype wire

// File: verification/ocf_host.sv
// Host model for the register port: one-cycle write and read strobes.
// Assumes the block samples on the rising edge; requests launch on the fall.
`timescale 1ns/1ps
`default_nettype none
module ocf_host (
  input wire logic clock,
  output var ocf_pkg::ocf_req_s reg_req,
  input wire logic [15:0] rd_data_r,
  input wire logic rd_valid_r
);
  initial reg_req = '0;
  task automatic put(input logic [7:0] c, input logic [15:0] d);
    @(negedge clock);
    reg_req <= '{wr: 1'b1, rd: 1'b0, code: c, data: d};
    @(negedge clock);
    reg_req <= '0;
  endtask
  // Answer stands one cycle only, so it is taken at the next fall
  task automatic get(input logic [7:0] c, output logic [15:0] d, output logic v);
    @(negedge clock);
    reg_req <= '{wr: 1'b0, rd: 1'b1, code: c, data: 16'h0000};
    @(negedge clock);
    reg_req <= '0;
    v = rd_valid_r;
    d = rd_data_r;
  endtask
endmodule // ocf_host
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the over-current fault controller.
// Assumes the host model drives registers; one tick is one clock to keep delays short.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock = 1'b0, sys_rst = 1'b1, vout_low = 1'b0, output_on_cmd = 1'b0, bias_ok = 1'b1;
  logic other_fault = 1'b0, fault_clear = 1'b0, ok, rd_valid_r, out_enable_r, clamp_active_r;
  logic oc_status_r, host_notify_r;
  logic [15:0] iout_meas = 16'h0000, rd_data_r, current_limit_r, val;
  logic [2:0] attempts_r;
  ocf_pkg::ocf_req_s reg_req;
  int n_fail = 0, comparisons = 0, n;
  always #25 clock = ~clock;
  ocf_host u_host (.clock(clock), .reg_req(reg_req), .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r));
  ocf_fault_ctrl #(
    .TICK_CYCLES(1)
  ) u_dut (
    .clock(clock),
    .sys_rst(sys_rst),
    .reg_req(reg_req),
    .iout_meas(iout_meas),
    .vout_low(vout_low),
    .output_on_cmd(output_on_cmd),
    .bias_ok(bias_ok),
    .other_fault(other_fault),
    .fault_clear(fault_clear),
    .rd_data_r(rd_data_r),
    .rd_valid_r(rd_valid_r),
    .out_enable_r(out_enable_r),
    .clamp_active_r(clamp_active_r),
    .current_limit_r(current_limit_r),
    .oc_status_r(oc_status_r),
    .host_notify_r(host_notify_r),
    .attempts_r(attempts_r)
  );
  task automatic chk(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %b", $time, got);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(negedge clock);
  endtask
  task automatic cfg(input logic [7:0] v, input logic [7:0] u);
    u_host.put(ocf_pkg::CMD_REACTION, {8'h00, v});
    u_host.put(ocf_pkg::CMD_TIME_UNIT, {8'h00, u});
  endtask
  task automatic clr();
    fault_clear = 1'b1;
    cyc(1);
    fault_clear = 1'b0;
  endtask
  // Bounded so a stuck output cannot hang the run
  task automatic wait_for(input logic sel, input logic v);
    n = 0;
    while (n < 1000 && (sel ? clamp_active_r : out_enable_r) !== v) begin
      cyc(1);
      n++;
    end
  endtask
  task automatic rises(output int k);
    logic p;
    k = 0;
    repeat (300) begin
      p = out_enable_r;
      cyc(1);
      k += int'(out_enable_r && !p);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(20);
    sys_rst = 1'b0;
    u_host.get(ocf_pkg::CMD_THRESHOLD, val, ok);
    chk(ok && val === ocf_pkg::THRESHOLD_RST && current_limit_r === val, 1'b1);
    u_host.get(8'h10, val, ok);
    chk(ok && val === 16'h0000, 1'b1);
    u_host.put(ocf_pkg::CMD_THRESHOLD, 16'h0100);
    u_host.get(ocf_pkg::CMD_THRESHOLD, val, ok);
    chk(val === 16'h0100 && current_limit_r === val, 1'b1);
    output_on_cmd = 1'b1;
    cfg(8'h00, 8'h00);
    iout_meas = 16'h0101;
    cyc(1);
    chk(host_notify_r && oc_status_r && clamp_active_r, 1'b1);
    vout_low = 1'b1;
    cyc(100);
    chk(out_enable_r && clamp_active_r, 1'b1);
    cfg(8'h40, 8'h00);
    chk(out_enable_r, 1'b0);
    cyc(50);
    chk(out_enable_r, 1'b0);
    vout_low = 1'b0;
    // Equal to the limit is not over it
    iout_meas = 16'h0100;
    clr();
    cyc(2);
    chk(out_enable_r && attempts_r === 3'h0, 1'b1);
    cfg(8'hCB, 8'h01);
    iout_meas = 16'h0200;
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
    // Eight units of two ticks from the shutdown edge
    chk(n == 16, 1'b1);
    cyc(20);
    chk(!out_enable_r && attempts_r === 3'h1, 1'b1);
    for (int k = 0; k < 8; k++) begin
      iout_meas = 16'h0000;
      clr();
      chk(attempts_r === 3'h0, 1'b1);
      cfg({2'b11, k[2:0], 3'b000}, 8'h00);
      iout_meas = 16'h0200;
      rises(n);
      chk(k < 7 ? n == k : n > 50, 1'b1);
      output_on_cmd = 1'b0;
      cyc(3);
      // Off command keeps the output off, latched or not
      chk(out_enable_r, 1'b0);
      output_on_cmd = 1'b1;
    end
    iout_meas = 16'h0000;
    clr();
    cfg(8'h82, 8'h00);
    iout_meas = 16'h0200;
    wait_for(1'b1, 1'b1);
    wait_for(1'b0, 1'b0);
    chk(n == 4, 1'b1);
    summarize();
  end
  initial begin
    repeat (10000) @(posedge clock);
    n_fail++;
    summarize();
  end
endmodule // testbench
bind ocf_fault_ctrl ocf_monitor u_mon (
  .clock(clock),
  .sys_rst(sys_rst),
  .reg_req(reg_req),
  .iout_meas(iout_meas),
  .vout_low(vout_low),
  .output_on_cmd(output_on_cmd),
  .bias_ok(bias_ok),
  .other_fault(other_fault),
  .fault_clear(fault_clear),
  .rd_data_r(rd_data_r),
  .rd_valid_r(rd_valid_r),
  .out_enable_r(out_enable_r),
  .clamp_active_r(clamp_active_r),
  .current_limit_r(current_limit_r),
  .oc_status_r(oc_status_r),
  .host_notify_r(host_notify_r),
  .attempts_r(attempts_r)
);
`default_nettype wire
